// ---- hdl/spa_serial_slave.sv ----
`timescale 1ns/100ps
`default_nettype none
module spa_serial_slave import spa_pkg::*; #(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Serial line
   input  wire logic       rxd,
   output logic            txd,
   output logic            txEnable,
   // Configuration
   input  wire logic [3:0] baudSelectParam,
   input  wire logic [4:0] nodeAddressParam,
   input  wire logic       serialReinitCommand,
   input  wire logic       configStoreCommand,
   output logic      [3:0] activeBaud,
   output logic      [4:0] activeNode,
   output logic            configSave,
   // Parameter and program store
   output logic            parReq,
   output logic            parWe,
   output logic            parProgram,
   output logic     [12:0] parAddr,
   output logic      [7:0] parWrData,
   input  wire logic [7:0] parRdData,
   // Written instruction decode
   output logic            instrValid,
   output logic      [3:0] instrOpcode,
   output logic      [3:0] instrArg,
   output logic            instrLong,
   output logic            instrFastNop
);

   typedef struct packed {
      spa_st_e         st;
      logic [3:0]      baud;
      logic [4:0]      node;
      logic            esc;
      logic [1:0]      idx;
      logic [2:0]      cmd;
      logic [4:0]      dst;
      logic [4:0]      bk;
      logic [2:0]      cnt;
      logic [7:0]      par;
      logic [3:0][7:0] dat;
      logic [2:0]      dn;
      logic [7:0]      sum;
      logic [15:0]     sub;
      logic [9:0]      ms;
      logic [2:0]      ai;
      logic            ph;
      logic [3:0]      tk;
      logic            stf;
      logic            ts;
      logic [7:0]      tb;
      logic            txEn;
      logic            cfgSave;
      logic            pReq;
      logic            pWe;
      logic            pPrg;
      logic [12:0]     pAddr;
      logic [7:0]      pWd;
      logic            iVal;
      logic [3:0]      iOp;
      logic [3:0]      iArg;
      logic            iLong;
      logic            iNop;
   } spa_core_s;

   localparam spa_core_s RESET_S = '{st: S_HUNT, baud: BAUD_RESET, node: NODE_RESET,
                                     default: '0};

   spa_core_s  q;
   spa_core_s  d;
   spa_uart_if u ();

   // Character engine
   spa_uart i_uart (
      .clk   (clk),
      .reset (reset),
      .rxd   (rxd),
      .txd   (txd),
      .u     (u.phy)
   );

   // Frame parser, store access and reply sequencer
   always_comb begin
      logic        take;
      logic [7:0]  v;
      logic [1:0]  ri;
      logic [7:0]  rs;
      logic [2:0]  rn;
      logic        rd;
      logic        bm;
      logic        ok;
      logic [12:0] a;
      logic [7:0]  nb;
      logic [7:0]  wd;
      d    = q;
      take = 1'b0;
      v    = u.rxByte;
      ri   = q.idx;
      rs   = q.sum;
      rn   = q.dn;
      rd   = (q.cmd == CMD_PRG_RD) || (q.cmd == CMD_PAR_RD);
      bm   = (q.cmd == CMD_BIT_MOD);
      ok   = (q.cnt >= COUNT_MIN) && (q.cnt <= COUNT_MAX) && (!bm || q.cnt == COUNT_BMOD) &&
             (q.cmd != CMD_RESP) && (q.cmd == CMD_BCAST ? {q.cmd, q.dst} == BCAST_BYTE
                                                        : q.dst == q.node);
      a    = {q.bk, q.par} + 13'(q.ai);
      nb   = START_BYTE;
      wd   = bm ? ((parRdData & q.dat[0]) | (q.dat[1] & ~q.dat[0])) : q.dat[q.ai[1:0]];
      d.ts      = 1'b0;
      d.pReq    = 1'b0;
      d.iVal    = 1'b0;
      d.cfgSave = configStoreCommand;
      // Settings change only on the reinit command
      if (serialReinitCommand) begin
         d.baud = baudSelectParam;
         d.node = nodeAddressParam;
      end
      case (q.st)
         S_HUNT: begin
            if (u.rxValid && !u.rxErr && u.rxByte == START_BYTE) begin
               d.st  = S_RX;
               d.idx = '0;
               d.dn  = '0;
               d.sum = '0;
               d.esc = 1'b0;
               d.sub = '0;
               d.ms  = '0;
            end
         end
         S_RX: begin
            // Millisecond time base counts from the start byte
            if (q.sub == 16'(MS_CYCLES - 1)) begin
               d.sub = '0;
               d.ms  = q.ms + 10'h1;
            end else begin
               d.sub = q.sub + 16'h1;
            end
            if (q.ms >= spaTimeoutMs(q.baud)) begin
               d.st = S_HUNT;
            end else if (u.rxValid) begin
               if (u.rxErr) begin
                  d.st = S_HUNT;
               end else if (!q.esc && v == START_BYTE) begin
                  d.esc = 1'b1;
               end else if (q.esc && v == STUFF_BYTE) begin
                  d.esc = 1'b0;
                  take  = 1'b1;
                  v     = START_BYTE;
               end else begin
                  // Unstuffed 7E was a fresh start byte
                  if (q.esc) begin
                     ri    = '0;
                     rs    = '0;
                     rn    = '0;
                     d.sub = '0;
                     d.ms  = '0;
                  end
                  d.esc = (v == START_BYTE);
                  take  = (v != START_BYTE);
               end
            end
            if (take) begin
               d.sum = rs + v;
               case (ri)
                  2'd0: begin
                     d.cmd = v[7:5];
                     d.dst = v[4:0];
                     d.idx = 2'd1;
                     d.dn  = '0;
                     if (v == '0) begin
                        d.st = S_HUNT;
                     end
                  end
                  2'd1: begin
                     d.cnt = v[2:0];
                     d.bk  = v[7:3];
                     d.idx = 2'd2;
                  end
                  2'd2: begin
                     d.par = v;
                     d.idx = 2'd3;
                  end
                  default: begin
                     if (rd || rn == q.cnt) begin
                        d.st = S_HUNT;
                        if (v == rs && ok) begin
                           d.st = S_ACC;
                           d.ai = '0;
                           d.ph = 1'b0;
                        end
                     end else begin
                        d.dat[rn[1:0]] = v;
                        d.dn = rn + 3'h1;
                     end
                  end
               endcase
            end
         end
         S_ACC: begin
            d.pPrg  = (q.cmd == CMD_PRG_RD) || (q.cmd == CMD_PRG_WR);
            d.pAddr = a;
            d.tk    = '0;
            d.stf   = 1'b0;
            d.sum   = '0;
            d.sub   = '0;
            if (!q.ph && (rd || bm)) begin
               d.pReq = 1'b1;
               d.pWe  = 1'b0;
               d.ph   = 1'b1;
            end else if (rd) begin
               d.dat[q.ai[1:0]] = parRdData;
               d.ph = 1'b0;
               d.ai = q.ai + 3'h1;
               if (q.ai == q.cnt - 3'h1) begin
                  d.st   = S_TX;
               end
            end else begin
               d.pReq = 1'b1;
               d.pWe  = 1'b1;
               d.pWd  = wd;
               d.ai   = q.ai + 3'h1;
               // Decode the first byte of each written instruction
               if (q.cmd == CMD_PRG_WR && !a[0]) begin
                  d.iVal  = 1'b1;
                  d.iOp   = wd[3:0];
                  d.iArg  = wd[7:4];
                  d.iLong = (wd[3:0] >= OP_ARITH_LO) && (wd[3:0] <= OP_ARITH_HI);
                  d.iNop  = (wd[3:0] == OP_FAST_COPY) && (a >= FAST_COPY_END);
               end
               if (bm || q.ai == q.cnt - 3'h1) begin
                  d.st   = (q.cmd == CMD_BCAST) ? S_HUNT : S_TX;
               end
            end
         end
         S_TX: begin
            case (q.tk)
               4'd0:    nb = START_BYTE;
               4'd1:    nb = {CMD_RESP, q.node};
               4'd2:    nb = {q.bk, q.cnt};
               4'd3:    nb = q.par;
               default: nb = (q.tk - TX_FIRST_DATA < 4'(q.cnt)) ?
                             q.dat[2'(q.tk - TX_FIRST_DATA)] : q.sum;
            endcase
            if (q.tk == '0 && q.sub != u.div[16:1]) begin
               d.sub = q.sub + 16'h1; // Master's stop bit must end before we drive
            end else if (u.txReady && !q.ts) begin
               // Last byte has fully left the shifter
               if (!q.stf && q.tk == (rd ? TX_FIRST_DATA + 4'(q.cnt) + 4'h1 : 4'h2)) begin
                  d.st   = S_HUNT;
                  d.txEn = 1'b0;
               end else if (q.stf) begin
                  d.ts  = 1'b1;
                  d.tb  = STUFF_BYTE;
                  d.stf = 1'b0;
               end else begin
                  d.ts  = 1'b1;
                  d.tb  = nb;
                  d.txEn = 1'b1;
                  d.tk  = q.tk + 4'h1;
                  d.sum = (q.tk == '0) ? q.sum : q.sum + nb;
                  d.stf = (q.tk != '0) && (nb == START_BYTE);
               end
            end
         end
         default: d = RESET_S;
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= RESET_S;
      end else begin
         q <= d;
      end
   end

   // Character engine hookup
   assign u.div     = spaBitCycles(q.baud);
   assign u.txStart = q.ts;
   assign u.txByte  = q.tb;

   // Outputs, all from the state register
   assign txEnable     = q.txEn;
   assign activeBaud   = q.baud;
   assign activeNode   = q.node;
   assign configSave   = q.cfgSave;
   assign parReq       = q.pReq;
   assign parWe        = q.pWe;
   assign parProgram   = q.pPrg;
   assign parAddr      = q.pAddr;
   assign parWrData    = q.pWd;
   assign instrValid   = q.iVal;
   assign instrOpcode  = q.iOp;
   assign instrArg     = q.iArg;
   assign instrLong    = q.iLong;
   assign instrFastNop = q.iNop;

   a_reset_config: assert property (@(posedge clk) disable iff (reset)
      $past(reset) |-> q.baud == BAUD_RESET && q.node == NODE_RESET)
      else $error("reset configuration wrong");
   a_config_hold: assert property (@(posedge clk) disable iff (reset)
      !$past(serialReinitCommand) |-> $stable(q.baud) && $stable(q.node))
      else $error("configuration changed without reinit");
   a_rate_map: assert property (@(posedge clk) disable iff (reset)
      serialReinitCommand && baudSelectParam == 4'h8 |=> u.div == 17'(CLK_HZ / 57600))
      else $error("bit period wrong for top rate");
   a_timeout_bound: assert property (@(posedge clk) disable iff (reset)
      q.st == S_RX |-> q.ms <= spaTimeoutMs(q.baud))
      else $error("frame outlived its time-out");
   a_stuff_follows: assert property (@(posedge clk) disable iff (reset)
      $fell(q.stf) && q.st == S_TX |-> q.ts && q.tb == STUFF_BYTE)
      else $error("7E not followed by stuffed zero");
   a_bcast_silent: assert property (@(posedge clk) disable iff (reset)
      q.st == S_ACC && q.cmd == CMD_BCAST |=> !q.txEn && q.st != S_TX)
      else $error("reply to broadcast");
   a_line_quiet: assert property (@(posedge clk) disable iff (reset)
      q.st == S_HUNT || q.st == S_RX |-> !q.txEn)
      else $error("line driven while not answering");
   a_bit_change: assert property (@(posedge clk) disable iff (reset)
      q.st == S_ACC && q.cmd == CMD_BIT_MOD && q.ph |=> parWe && parReq &&
      parWrData == (($past(parRdData) & q.dat[0]) | (q.dat[1] & ~q.dat[0])))
      else $error("bit change data wrong");
   a_fast_ignore: assert property (@(posedge clk) disable iff (reset)
      instrValid && instrOpcode == OP_FAST_COPY |-> instrFastNop == (parAddr >= FAST_COPY_END))
      else $error("fast copy position check wrong");
   a_instr_len: assert property (@(posedge clk) disable iff (reset)
      instrValid |-> instrLong == (instrOpcode >= OP_ARITH_LO && instrOpcode <= OP_ARITH_HI))
      else $error("instruction length wrong");

endmodule
`default_nettype wire

// ---- hdl/spa_pkg.sv ----
package spa_pkg;

   // Clock and time base
   localparam int CLK_HZ        = 40_000_000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS         = 1_000_000;
   localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

   // Framing bytes and command codes
   localparam logic [7:0] START_BYTE  = 8'h7e;
   localparam logic [7:0] STUFF_BYTE  = 8'h00;
   localparam logic [7:0] BCAST_BYTE  = 8'he0;
   localparam logic [2:0] CMD_RESP    = 3'h1;
   localparam logic [2:0] CMD_PRG_RD  = 3'h2;
   localparam logic [2:0] CMD_PRG_WR  = 3'h3;
   localparam logic [2:0] CMD_PAR_RD  = 3'h4;
   localparam logic [2:0] CMD_BIT_MOD = 3'h6;
   localparam logic [2:0] CMD_BCAST   = 3'h7;
   localparam logic [2:0] COUNT_MIN   = 3'h1;
   localparam logic [2:0] COUNT_MAX   = 3'h4;
   localparam logic [2:0] COUNT_BMOD  = 3'h2;
   localparam logic [3:0] TX_FIRST_DATA = 4'h4;

   // Reset configuration
   localparam logic [3:0] BAUD_RESET = 4'h5;
   localparam logic [4:0] NODE_RESET = 5'h00;

   // Stored instruction encoding
   localparam logic [3:0] OP_ARITH_LO   = 4'h8;
   localparam logic [3:0] OP_ARITH_HI   = 4'hb;
   localparam logic [3:0] OP_FAST_COPY  = 4'he;
   localparam logic [12:0] FAST_COPY_END = 13'h0004;

   // Character framing: start, 8 data, parity, stop
   localparam logic [3:0] CHAR_LAST = 4'ha;

   typedef enum logic [3:0] {
      S_HUNT = 4'h1,
      S_RX   = 4'h2,
      S_ACC  = 4'h4,
      S_TX   = 4'h8
   } spa_st_e;

   // Clock cycles per bit for each rate code
   function automatic logic [16:0] spaBitCycles(input logic [3:0] code);
      case (code)
         4'h0:    spaBitCycles = 17'(CLK_HZ / 600);
         4'h1:    spaBitCycles = 17'(CLK_HZ / 1200);
         4'h2:    spaBitCycles = 17'(CLK_HZ / 2400);
         4'h3:    spaBitCycles = 17'(CLK_HZ / 4800);
         4'h6:    spaBitCycles = 17'(CLK_HZ / 19200);
         4'h7:    spaBitCycles = 17'(CLK_HZ / 38400);
         4'h8:    spaBitCycles = 17'(CLK_HZ / 57600);
         default: spaBitCycles = 17'(CLK_HZ / 9600);
      endcase
   endfunction

   // Message time-out in ms for each rate code
   function automatic logic [9:0] spaTimeoutMs(input logic [3:0] code);
      case (code)
         4'h0:    spaTimeoutMs = 10'd512;
         4'h1:    spaTimeoutMs = 10'd256;
         4'h2:    spaTimeoutMs = 10'd128;
         4'h3:    spaTimeoutMs = 10'd64;
         4'h6:    spaTimeoutMs = 10'd16;
         4'h7:    spaTimeoutMs = 10'd12;
         4'h8:    spaTimeoutMs = 10'd8;
         default: spaTimeoutMs = 10'd32;
      endcase
   endfunction

endpackage

// ---- hdl/spa_uart_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface spa_uart_if;
   logic [16:0] div;
   logic [7:0]  rxByte;
   logic        rxValid;
   logic        rxErr;
   logic [7:0]  txByte;
   logic        txStart;
   logic        txReady;
   modport core (output div, txByte, txStart, input rxByte, rxValid, rxErr, txReady);
   modport phy  (input div, txByte, txStart, output rxByte, rxValid, rxErr, txReady);
endinterface
`default_nettype wire

// ---- hdl/spa_uart.sv ----
`timescale 1ns/100ps
`default_nettype none
module spa_uart import spa_pkg::*; (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Line
   input  wire logic rxd,
   output logic      txd,
   // Core side
   spa_uart_if.phy   u
);

   typedef struct packed {
      logic        rb;
      logic [16:0] rc;
      logic [3:0]  rn;
      logic [9:0]  rs;
      logic        rv;
      logic        re;
      logic [7:0]  rbyte;
      logic        tb;
      logic [16:0] tc;
      logic [3:0]  tn;
      logic [10:0] ts;
   } spa_uart_s;

   localparam spa_uart_s RESET_S = '{ts: '1, default: '0};

   spa_uart_s q;
   spa_uart_s d;

   // Receiver samples mid-bit; transmitter shifts one frame
   always_comb begin
      d = q;
      d.rv = 1'b0;
      d.re = 1'b0;
      if (!q.rb) begin
         if (!rxd) begin
            d.rb = 1'b1;
            d.rc = {1'b0, u.div[16:1]};
            d.rn = '0;
         end
      end else if (q.rc != '0) begin
         d.rc = q.rc - 17'h1;
      end else begin
         d.rc = u.div - 17'h1;
         d.rn = q.rn + 4'h1;
         if (q.rn == '0) begin
            d.rb = ~rxd; // High at mid-start is a glitch
         end else begin
            d.rs = {rxd, q.rs[9:1]};
            if (q.rn == CHAR_LAST) begin
               d.rb    = 1'b0;
               d.rv    = 1'b1;
               d.rbyte = d.rs[7:0];
               d.re    = (^d.rs[8:0]) | ~d.rs[9]; // Even parity and stop
            end
         end
      end
      if (!q.tb) begin
         if (u.txStart) begin
            d.tb = 1'b1;
            d.ts = {1'b1, ^u.txByte, u.txByte, 1'b0};
            d.tc = u.div - 17'h1;
            d.tn = '0;
         end
      end else if (q.tc != '0) begin
         d.tc = q.tc - 17'h1;
      end else begin
         d.tc = u.div - 17'h1;
         d.tn = q.tn + 4'h1;
         d.ts = {1'b1, q.ts[10:1]};
         d.tb = (q.tn != CHAR_LAST);
      end
   end

   // State register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         q <= RESET_S;
      end else begin
         q <= d;
      end
   end

   assign txd       = q.ts[0];
   assign u.rxByte  = q.rbyte;
   assign u.rxValid = q.rv;
   assign u.rxErr   = q.re;
   assign u.txReady = ~q.tb;

   a_char_start: assert property (@(posedge clk) disable iff (reset)
      u.txStart && !q.tb |=> !txd ##1 !txd)
      else $error("start bit not driven low");
   a_char_stop: assert property (@(posedge clk) disable iff (reset)
      q.tb && q.tn == CHAR_LAST |-> txd)
      else $error("stop bit not high");

endmodule
`default_nettype wire

// ---- bench/spa_store_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module spa_store_model (
   // Clock
   input  wire logic        clk,
   // Store port
   input  wire logic        parReq,
   input  wire logic        parWe,
   input  wire logic        parProgram,
   input  wire logic [12:0] parAddr,
   input  wire logic [7:0]  parWrData,
   output logic      [7:0]  parRdData
);
   logic [7:0] mem [512];

   // Program bytes kept apart from parameter bytes by the area flag
   always @(posedge clk) begin
      if (parReq && parWe) begin
         mem[{parProgram, parAddr[7:0]}] <= parWrData;
      end
   end

   // Data valid only while the read request stands; inverted otherwise
   assign parRdData = (parReq && !parWe) ? mem[{parProgram, parAddr[7:0]}]
                                         : ~mem[{parProgram, parAddr[7:0]}];
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top import spa_pkg::*;;
   localparam int BIT_CYC = CLK_HZ / 57600;

   logic clk = 1'b0;
   logic reset, rxd, txd, txEnable, reinit, storeCmd, configSave, sending, quiet;
   logic [3:0] baudSel, activeBaud, instrOpcode, instrArg;
   logic [4:0] nodeSel, activeNode;
   logic parReq, parWe, parProgram, instrValid, instrLong, instrFastNop;
   logic [12:0] parAddr;
   logic [7:0] parWrData, parRdData;
   logic [9:0] instrCap;
   int nErrors = 0;
   int totalChecks = 0;
   int instrSeen = 0;

   spa_serial_slave i_dut (
      .clk(clk), .reset(reset), .rxd(rxd), .txd(txd), .txEnable(txEnable),
      .baudSelectParam(baudSel), .nodeAddressParam(nodeSel),
      .serialReinitCommand(reinit), .configStoreCommand(storeCmd),
      .activeBaud(activeBaud), .activeNode(activeNode), .configSave(configSave),
      .parReq(parReq), .parWe(parWe), .parProgram(parProgram), .parAddr(parAddr),
      .parWrData(parWrData), .parRdData(parRdData), .instrValid(instrValid),
      .instrOpcode(instrOpcode), .instrArg(instrArg), .instrLong(instrLong),
      .instrFastNop(instrFastNop)
   );

   spa_store_model i_store (
      .clk(clk), .parReq(parReq), .parWe(parWe), .parProgram(parProgram),
      .parAddr(parAddr), .parWrData(parWrData), .parRdData(parRdData)
   );

   always #12.5 clk = ~clk;

   // Capture decoded instruction while its pulse stands
   always @(negedge clk) begin
      if (instrValid === 1'b1) begin
         instrSeen <= instrSeen + 1;
         instrCap <= {instrLong, instrFastNop, instrArg, instrOpcode};
      end
   end

   // Half duplex: never talk over the master
   always @(negedge clk) begin
      if (sending) begin
         check("line idle while receiving", txEnable, 1'b0);
      end
   end

   task automatic printVerdict();
      $display("checks %0d errors %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One character, LSB first, even parity unless corrupted on purpose
   task automatic send_char(input logic [7:0] b, input logic badPar);
      logic [10:0] f;
      f = {1'b1, ^b ^ badPar, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd = f[i];
         repeat (BIT_CYC) @(negedge clk);
      end
   endtask

   // Master request: start byte, fields, sum, stuffing after inner 7E
   task automatic send_frame(input logic [7:0] q[$]);
      logic [7:0] s;
      s = 8'h00;
      sending = 1'b1;
      send_char(START_BYTE, 1'b0);
      foreach (q[i]) s += q[i];
      q.push_back(s);
      foreach (q[i]) begin
         send_char(q[i], 1'b0);
         if (q[i] == START_BYTE) send_char(STUFF_BYTE, 1'b0);
      end
      sending = 1'b0;
   endtask

   // Receive one character from txd, sampled at mid-bit
   task automatic get_char(output logic [7:0] b);
      logic [10:0] f;
      int n;
      n = 0;
      while (txd !== 1'b0 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      if (n == 20000) begin
         nErrors++;
         printVerdict();
      end
      repeat (BIT_CYC / 2) @(negedge clk);
      for (int i = 0; i < 11; i++) begin
         f[i] = txd;
         if (i < 10) repeat (BIT_CYC) @(negedge clk);
      end
      check("stop start parity", {f[10], f[0], ^f[9:1]}, 3'b100);
      b = f[8:1];
   endtask

   task automatic expect_frame(input logic [7:0] q[$], input logic withSum);
      logic [7:0] s, b;
      int n;
      s = 8'h00;
      get_char(b);
      check("reply start", b, START_BYTE);
      foreach (q[i]) s += q[i];
      if (withSum) q.push_back(s);
      foreach (q[i]) begin
         get_char(b);
         check("reply byte", b, q[i]);
         if (q[i] == START_BYTE) begin
            get_char(b);
            check("reply stuff", b, STUFF_BYTE);
         end
      end
      n = 0;
      while (txEnable !== 1'b0 && n < 4 * BIT_CYC) begin
         @(negedge clk);
         n++;
      end
      if (n == 4 * BIT_CYC) begin
         nErrors++;
         printVerdict();
      end
      check("line released", {txEnable, txd}, 2'b01);
   endtask

   initial begin
      reset = 1'b1;
      rxd = 1'b1;
      baudSel = 4'h8;
      nodeSel = 5'h03;
      reinit = 1'b0;
      storeCmd = 1'b0;
      sending = 1'b0;
      quiet = 1'b1;
      i_store.mem[9'h032] = 8'h28;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      // New settings must wait for the reinit command
      check("reset rate", activeBaud, 4'h5);
      check("reset node", activeNode, 5'h00);
      reinit = 1'b1;
      @(negedge clk);
      reinit = 1'b0;
      check("rate after reinit", activeBaud, 4'h8);
      check("node after reinit", activeNode, 5'h03);
      storeCmd = 1'b1;
      @(negedge clk);
      storeCmd = 1'b0;
      check("store pulse", configSave, 1'b1);
      @(negedge clk);
      check("store pulse end", configSave, 1'b0);
      // Program write of first instruction, acknowledged with two bytes
      send_frame('{8'h63, 8'h02, 8'h00, 8'h40, 8'h5a});
      expect_frame('{8'h23}, 1'b0);
      check("instr pulses", 16'(instrSeen), 16'h0001);
      check("instr decode", instrCap, 10'h040);
      check("program bytes", {i_store.mem[9'h100], i_store.mem[9'h101]}, 16'h405a);
      // Parameter read whose reply sum equals the start byte
      send_frame('{8'h83, 8'h01, 8'h32});
      expect_frame('{8'h23, 8'h01, 8'h32, 8'h28}, 1'b1);
      // Bit change: mask keeps high nibble, new value's high nibble ignored
      send_frame('{8'hc3, 8'h02, 8'h32, 8'hf0, 8'ha5});
      expect_frame('{8'h23}, 1'b0);
      check("bit change", i_store.mem[9'h032], 8'h25);
      // Parity error mid-frame: no answer at all
      sending = 1'b1;
      send_char(START_BYTE, 1'b0);
      send_char(8'h83, 1'b1);
      sending = 1'b0;
      repeat (4 * BIT_CYC) begin
         @(negedge clk);
         if (txEnable !== 1'b0) quiet = 1'b0;
      end
      check("silent on error", quiet, 1'b1);
      printVerdict();
   end
endmodule
`default_nettype wire
